// >>> rtl/ufb_baud_gen.sv
// programmable divider producing the 16x bit-rate tick
`timescale 1ns/10ps
module ufb_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    input  wire logic             load_i,
    output logic                  tick16_o
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             next_tick16;

    // count down each clock, tick and reload on expiry; a write reloads at once
    always_comb begin
        next_count  = count;
        next_tick16 = 1'b0;
        if (load_i) begin
            next_count = divisor_i; // R13
        end else if (divisor_i != '0) begin // R11
            if (count <= DIV_W'(1)) begin
                next_tick16 = 1'b1; // R10
                next_count  = divisor_i; // R19
            end else begin
                next_count = count - DIV_W'(1); // R19
            end
        end
    end

    // a zero divisor means unprogrammed: no ticks rather than a runaway rate
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            count    <= '0;
            tick16_o <= 1'b0;
        end else begin
            count    <= next_count;
            tick16_o <= next_tick16;
        end
    end
endmodule : ufb_baud_gen

// >>> rtl/ufb_consts.svh
// register offsets, field positions and reset values of the format and baud block
`ifndef UFB_CONSTS_SVH
`define UFB_CONSTS_SVH

// low addresses; 0 and 1 are shared and routed by the bank select bit, 3 always selects the format register
`define UFB_OFS_DIV_LO        3'h0
`define UFB_OFS_DIV_HI        3'h1
`define UFB_OFS_LINE_FMT      3'h3

// line_format_control field positions
`define UFB_POS_LEN_LO        0
`define UFB_POS_LEN_HI        1
`define UFB_POS_STOP          2
`define UFB_POS_PARITY_ON     3
`define UFB_POS_EVEN          4
`define UFB_POS_FIXED         5
`define UFB_POS_BREAK         6
`define UFB_POS_BANK          7

// reset values
`define UFB_RST_LINE_FMT      8'h00
`define UFB_RST_DIV_BYTE      8'h00

// framing figures
`define UFB_MIN_DATA_BITS     4'h5
`define UFB_STOP_HALVES_ONE   3'h2
`define UFB_STOP_HALVES_ONEH  3'h3
`define UFB_STOP_HALVES_TWO   3'h4
`define UFB_TICKS_PER_BIT     8'h10
`define UFB_TICKS_PER_HALF    8'h08

`endif

// >>> rtl/ufb_format_baud.sv
// character format register, divisor latches, bank routing and break override
`timescale 1ns/10ps
`include "ufb_consts.svh"

// Behaviour
// R1 - two low format bits give five to eight data bits, both directions
// R2 - stop select clear gives one stop bit whatever the length
// R3 - stop select set with five-bit characters gives one and a half stops
// R4 - stop select set with six to eight bits gives two stops
// R5 - parity on inserts and checks a parity bit after the data
// R6 - even select clear gives odd ones total, set gives even total
// R7 - fixed parity sends and expects the inverse of even select
// R8 - break force holds serial output low until software clears it
// R9 - bank select routes shared low addresses to divisor or forwarded registers
// R10 - divider produces a tick sixteen times the bit rate
// R11 - any divisor from one to 65535 is accepted
// R12 - divisor is one 16-bit value in two byte latches
// R13 - writing either divisor byte reloads the counter at once
// R14 - software programs both divisor bytes before using the line
// R15 - software avoids divisor one with a 1.8432 MHz reference
// R16 - software avoids divisor one or two with 3.072 MHz reference
// R17 - software keeps the line rate at or below 56K baud
// R18 - the reference clock stays at or below 3.1 MHz
// R19 - counter counts down per clock, ticks and reloads every divisor cycles
// R20 - parity off ignores even and fixed select and sends no bit
module ufb_format_baud #(
    parameter int DIV_W = 16
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    input  wire ufb_pkg::ufb_bus_req_t bus_req_i,
    input  wire logic [7:0]           fwd_rdata_i,
    output logic [7:0]                rdata_o,
    output logic                      fwd_rd_o,
    output logic                      fwd_wr_o,
    output logic [2:0]                fwd_addr_o,
    output logic [7:0]                fwd_wdata_o,
    output ufb_pkg::ufb_format_t      fmt_o,
    output logic                      tick16_o,
    input  wire logic                 tx_line_i,
    output logic                      serial_tx_line_o,
    input  wire logic [7:0]           tx_data_i,
    output logic                      tx_parity_o,
    input  wire logic [7:0]           rx_data_i,
    input  wire logic                 rx_parity_i,
    output logic                      rx_parity_err_o
);
    import ufb_pkg::*;

    // register state
    logic [7:0]       line_format_control;
    logic [7:0]       div_lo;
    logic [7:0]       div_hi;
    logic             div_load;
    logic [7:0]       next_line_format_control;
    logic [7:0]       next_div_lo;
    logic [7:0]       next_div_hi;
    logic             next_div_load;

    // bus answer and forwarding state
    logic [7:0]       next_rdata;
    logic             next_fwd_rd;
    logic             next_fwd_wr;
    logic [2:0]       next_fwd_addr;
    logic [7:0]       next_fwd_wdata;
    ufb_sel_t         sel;
    logic             rd_take;
    logic             wr_take;

    // format and line state
    ufb_format_t      next_fmt;
    logic             next_serial_tx_line;
    logic [DIV_W-1:0] divisor;

    // route an address through the bank select bit; used for reads and writes
    function automatic ufb_sel_t ufb_route(input logic [2:0] addr, input logic bank);
        if (addr == `UFB_OFS_LINE_FMT) begin
            return UFB_SEL_LINE_FMT;
        end
        if (bank && addr == `UFB_OFS_DIV_LO) begin
            return UFB_SEL_DIV_LO; // R9
        end
        if (bank && addr == `UFB_OFS_DIV_HI) begin
            return UFB_SEL_DIV_HI; // R9
        end
        return UFB_SEL_FWD; // R9
    endfunction : ufb_route

    // decode the format register into what the shift engines need
    function automatic ufb_format_t ufb_decode(input logic [7:0] lfc);
        ufb_format_t f;
        logic [7:0]  bits_in_char;
        f             = '0;
        f.data_bits   = `UFB_MIN_DATA_BITS
                        + {2'b00, lfc[`UFB_POS_LEN_HI], lfc[`UFB_POS_LEN_LO]}; // R1
        if (!lfc[`UFB_POS_STOP]) begin
            f.stop_halves = `UFB_STOP_HALVES_ONE; // R2
        end else if (f.data_bits == `UFB_MIN_DATA_BITS) begin
            f.stop_halves = `UFB_STOP_HALVES_ONEH; // R3
        end else begin
            f.stop_halves = `UFB_STOP_HALVES_TWO; // R4
        end
        f.parity_on    = lfc[`UFB_POS_PARITY_ON]; // R5
        f.parity_even  = lfc[`UFB_POS_EVEN] & lfc[`UFB_POS_PARITY_ON]; // R6 R20
        f.parity_fixed = lfc[`UFB_POS_FIXED] & lfc[`UFB_POS_PARITY_ON]; // R7 R20
        f.brk          = lfc[`UFB_POS_BREAK];
        // start + data + parity in whole bits, stops in half bits
        bits_in_char   = 8'h01 + {4'h0, f.data_bits} + {7'h00, f.parity_on};
        f.frame_ticks  = 8'((bits_in_char * `UFB_TICKS_PER_BIT)
                         + ({5'h00, f.stop_halves} * `UFB_TICKS_PER_HALF));
        return f;
    endfunction : ufb_decode

    // bus request decode; a request without chip select is ignored
    always_comb begin
        rd_take = bus_req_i.cs & bus_req_i.rd & ~bus_req_i.wr;
        wr_take = bus_req_i.cs & bus_req_i.wr & ~bus_req_i.rd;
        sel     = (rd_take | wr_take)
                  ? ufb_route(bus_req_i.addr, line_format_control[`UFB_POS_BANK])
                  : UFB_SEL_NONE;
    end

    // register writes; any divisor byte write arms an immediate counter reload
    always_comb begin
        next_line_format_control = line_format_control;
        next_div_lo              = div_lo;
        next_div_hi              = div_hi;
        next_div_load            = 1'b0;
        if (wr_take) begin
            unique case (sel)
                UFB_SEL_LINE_FMT: begin
                    next_line_format_control = bus_req_i.wdata;
                end
                UFB_SEL_DIV_LO: begin
                    next_div_lo   = bus_req_i.wdata; // R12
                    next_div_load = 1'b1; // R13
                end
                UFB_SEL_DIV_HI: begin
                    next_div_hi   = bus_req_i.wdata; // R12
                    next_div_load = 1'b1; // R13
                end
                UFB_SEL_FWD, UFB_SEL_NONE: begin
                    next_div_load = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            line_format_control <= `UFB_RST_LINE_FMT;
            div_lo              <= `UFB_RST_DIV_BYTE;
            div_hi              <= `UFB_RST_DIV_BYTE;
            div_load            <= 1'b0;
        end else begin
            line_format_control <= next_line_format_control;
            div_lo              <= next_div_lo;
            div_hi              <= next_div_hi;
            div_load            <= next_div_load;
        end
    end

    // read answer held until the next read; forwarded accesses pass through
    always_comb begin
        next_rdata     = rdata_o;
        next_fwd_rd    = 1'b0;
        next_fwd_wr    = 1'b0;
        next_fwd_addr  = fwd_addr_o;
        next_fwd_wdata = fwd_wdata_o;
        if (rd_take) begin
            unique case (sel)
                UFB_SEL_LINE_FMT: next_rdata = line_format_control;
                UFB_SEL_DIV_LO:   next_rdata = div_lo; // R9
                UFB_SEL_DIV_HI:   next_rdata = div_hi; // R9
                UFB_SEL_FWD:      next_rdata = fwd_rdata_i; // R9
                UFB_SEL_NONE:     next_rdata = rdata_o;
            endcase
        end
        // the far registers see the bank-qualified strobe only
        if (sel == UFB_SEL_FWD) begin
            next_fwd_rd    = rd_take; // R9
            next_fwd_wr    = wr_take; // R9
            next_fwd_addr  = bus_req_i.addr;
            next_fwd_wdata = bus_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_o     <= 8'h00;
            fwd_rd_o    <= 1'b0;
            fwd_wr_o    <= 1'b0;
            fwd_addr_o  <= 3'h0;
            fwd_wdata_o <= 8'h00;
        end else begin
            rdata_o     <= next_rdata;
            fwd_rd_o    <= next_fwd_rd;
            fwd_wr_o    <= next_fwd_wr;
            fwd_addr_o  <= next_fwd_addr;
            fwd_wdata_o <= next_fwd_wdata;
        end
    end

    // decoded format follows the register that will hold it next cycle
    // break overrides whatever the transmitter drives, spacing until cleared
    always_comb begin
        next_fmt            = ufb_decode(next_line_format_control);
        next_serial_tx_line = next_line_format_control[`UFB_POS_BREAK]
                              ? 1'b0 : tx_line_i; // R8
    end

    // line idles marking after reset so the far end sees no false start
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fmt_o            <= ufb_decode(`UFB_RST_LINE_FMT);
            serial_tx_line_o <= 1'b1;
        end else begin
            fmt_o            <= next_fmt;
            serial_tx_line_o <= next_serial_tx_line;
        end
    end

    // the core clock is the reference; the rate limits are software's concern
    assign divisor = DIV_W'({div_hi, div_lo}); // R12 R14 R15 R16 R17 R18

    ufb_baud_gen #(
        .DIV_W      (DIV_W)
    ) u_baud_gen (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .divisor_i  (divisor),
        .load_i     (div_load),
        .tick16_o   (tick16_o)
    );

    ufb_parity_unit u_parity (
        .core_clk_i      (core_clk_i),
        .reset_i         (reset_i),
        .fmt_i           (fmt_o),
        .tx_data_i       (tx_data_i),
        .rx_data_i       (rx_data_i),
        .rx_parity_i     (rx_parity_i),
        .tx_parity_o     (tx_parity_o),
        .rx_parity_err_o (rx_parity_err_o)
    );

endmodule : ufb_format_baud

// >>> rtl/ufb_parity_unit.sv
// parity generation for transmit and parity check for receive
`timescale 1ns/10ps
module ufb_parity_unit (
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire ufb_pkg::ufb_format_t fmt_i,
    input  wire logic [7:0]         tx_data_i,
    input  wire logic [7:0]         rx_data_i,
    input  wire logic               rx_parity_i,
    output logic                    tx_parity_o,
    output logic                    rx_parity_err_o
);
    import ufb_pkg::*;

    logic next_tx_parity;
    logic next_rx_parity_err;
    logic tx_expect;
    logic rx_expect;

    // odd count of ones among the bits the character length keeps
    function automatic logic ufb_ones_odd(input logic [7:0] data, input logic [3:0] nbits);
        logic [7:0] mask;
        mask = 8'hff >> (4'h8 - nbits);
        return ^(data & mask); // R1
    endfunction : ufb_ones_odd

    // expected parity bit for one character under the current format
    function automatic logic ufb_parity_bit(input ufb_format_t f, input logic [7:0] data);
        if (f.parity_fixed) begin
            return ~f.parity_even; // R7
        end
        return ufb_ones_odd(data, f.data_bits) ^ ~f.parity_even; // R6
    endfunction : ufb_parity_bit

    // parity disabled: no bit sent, nothing flagged
    always_comb begin
        tx_expect          = ufb_parity_bit(fmt_i, tx_data_i);
        rx_expect          = ufb_parity_bit(fmt_i, rx_data_i);
        next_tx_parity     = fmt_i.parity_on & tx_expect; // R5 R20
        next_rx_parity_err = fmt_i.parity_on & (rx_parity_i != rx_expect); // R5 R20
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tx_parity_o     <= 1'b0;
            rx_parity_err_o <= 1'b0;
        end else begin
            tx_parity_o     <= next_tx_parity;
            rx_parity_err_o <= next_rx_parity_err;
        end
    end
endmodule : ufb_parity_unit

// >>> rtl/ufb_pkg.sv
// types shared by the format and baud block
package ufb_pkg;

    // one register bus request, sampled on the clock edge
    typedef struct packed {
        logic       cs;
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufb_bus_req_t;

    // decoded character format handed to the shift engines
    typedef struct packed {
        logic [3:0] data_bits;
        logic [2:0] stop_halves;
        logic       parity_on;
        logic       parity_even;
        logic       parity_fixed;
        logic       brk;
        logic [7:0] frame_ticks;
    } ufb_format_t;

    // target of a bus access after bank routing
    typedef enum logic [2:0] {
        UFB_SEL_NONE,
        UFB_SEL_LINE_FMT,
        UFB_SEL_DIV_LO,
        UFB_SEL_DIV_HI,
        UFB_SEL_FWD
    } ufb_sel_t;

endpackage : ufb_pkg

// >>> tb/ufb_far_regs.sv
// model of the far registers behind the forwarded accesses
`timescale 1ns/10ps
module ufb_far_regs (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire ufb_pkg::ufb_bus_req_t bus_req_i,
    input  wire logic                  fwd_wr_i,
    input  wire logic [2:0]            fwd_addr_i,
    input  wire logic [7:0]            fwd_wdata_i,
    output logic [7:0]                 rdata_o
);
    import ufb_pkg::*;
    logic [7:0] regs [8];
    // answer in the request cycle; unselected shows garbage, not the last value
    assign rdata_o = bus_req_i.cs ? regs[bus_req_i.addr] : ~regs[bus_req_i.addr];
    // store forwarded writes
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            regs <= '{default: 8'h00};
        end else if (fwd_wr_i) begin
            regs[fwd_addr_i] <= fwd_wdata_i;
        end
    end
endmodule : ufb_far_regs

// >>> tb/ufb_format_baud_checker.sv
// assertion checker for the format and baud block
`timescale 1ns/10ps
module ufb_format_baud_checker #(
    parameter int DIV_W = 16
) (
    input wire logic                  core_clk_i,
    input wire logic                  reset_i,
    input wire ufb_pkg::ufb_bus_req_t bus_req_i,
    input wire logic [7:0]            fwd_rdata_i,
    input wire logic [7:0]            rdata_o,
    input wire logic                  fwd_rd_o,
    input wire logic                  fwd_wr_o,
    input wire logic [2:0]            fwd_addr_o,
    input wire ufb_pkg::ufb_format_t  fmt_o,
    input wire logic                  tx_line_i,
    input wire logic                  serial_tx_line_o,
    input wire logic [7:0]            tx_data_i,
    input wire logic                  tx_parity_o,
    input wire logic [7:0]            rx_data_i,
    input wire logic                  rx_parity_i,
    input wire logic                  rx_parity_err_o
);
    import ufb_pkg::*;
    logic [7:0] mask;
    logic       exp_tx;
    logic       exp_rx;
    logic       lfc_wr;
    logic       fwd_acc;
    // expected parity; bank bit is not visible here, so 0 and 1 stay out of fwd_acc
    always_comb begin
        mask    = 8'hff >> (4'h8 - fmt_o.data_bits);
        exp_tx  = fmt_o.parity_fixed ? ~fmt_o.parity_even
                                     : ^(tx_data_i & mask) ^ ~fmt_o.parity_even;
        exp_rx  = fmt_o.parity_fixed ? ~fmt_o.parity_even
                                     : ^(rx_data_i & mask) ^ ~fmt_o.parity_even;
        lfc_wr  = bus_req_i.cs && bus_req_i.wr && !bus_req_i.rd && bus_req_i.addr == 3'h3;
        fwd_acc = bus_req_i.cs && (bus_req_i.rd ^ bus_req_i.wr)
                  && bus_req_i.addr inside {2, [4:7]};
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    AST_LEN: assert property (
        lfc_wr |=> fmt_o.data_bits == 4'h5 + $past(bus_req_i.wdata[1:0]))
        else $error("bad data bits");
    AST_STOP: assert property (
        lfc_wr |=> fmt_o.stop_halves == (!$past(bus_req_i.wdata[2]) ? 3'h2 :
            ($past(bus_req_i.wdata[1:0]) == 2'h0 ? 3'h3 : 3'h4)))
        else $error("bad stop count");
    AST_OFF: assert property (
        !fmt_o.parity_on |-> !fmt_o.parity_even && !fmt_o.parity_fixed
            ##1 !tx_parity_o && !rx_parity_err_o)
        else $error("parity active while off");
    AST_TXP: assert property (
        fmt_o.parity_on |=> tx_parity_o == $past(exp_tx))
        else $error("bad tx parity");
    AST_RXP: assert property (
        fmt_o.parity_on |=> rx_parity_err_o == ($past(rx_parity_i) != $past(exp_rx)))
        else $error("bad rx parity check");
    AST_BRK: assert property (
        fmt_o.brk |-> !serial_tx_line_o)
        else $error("line not held low in break");
    AST_BRK_HOLD: assert property (
        fmt_o.brk && !lfc_wr |=> fmt_o.brk)
        else $error("break dropped without write");
    AST_REL: assert property (
        !fmt_o.brk && !$past(fmt_o.brk) |-> serial_tx_line_o == $past(tx_line_i))
        else $error("line does not follow transmitter");
    AST_FWD: assert property (
        fwd_acc |=> fwd_rd_o == $past(bus_req_i.rd) && fwd_wr_o == $past(bus_req_i.wr)
            && fwd_addr_o == $past(bus_req_i.addr))
        else $error("access not forwarded");
    AST_FWD_RD: assert property (
        fwd_acc && bus_req_i.rd |=> rdata_o == $past(fwd_rdata_i))
        else $error("forwarded read data lost");
    AST_LFC_LOCAL: assert property (
        lfc_wr |=> !fwd_wr_o)
        else $error("format write leaked out");
endmodule : ufb_format_baud_checker

bind ufb_format_baud ufb_format_baud_checker #(.DIV_W(DIV_W)) i_chk (.*);

// >>> tb/ufb_format_baud_tb.sv
// self-checking bench for the format and baud block
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module ufb_format_baud_tb;
    import ufb_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         reset_i = 1'b1;
    ufb_bus_req_t bus_req_i = '0;
    ufb_format_t  fmt_o;
    logic [7:0]   fwd_rdata_i, rdata_o, fwd_wdata_o, tx_data_i = 8'h00, rx_data_i = 8'h00;
    logic [2:0]   fwd_addr_o;
    logic         fwd_rd_o, fwd_wr_o, tick16_o, serial_tx_line_o, tx_parity_o, rx_parity_err_o;
    logic         tx_line_i = 1'b1, rx_parity_i = 1'b0;
    int           n_fail = 0;
    int           num_checks = 0;

    always #10 core_clk_i = ~core_clk_i;

    ufb_format_baud #(.DIV_W(16)) i_dut (.*);
    ufb_far_regs i_far (.core_clk_i, .reset_i, .bus_req_i, .fwd_wr_i(fwd_wr_o),
        .fwd_addr_i(fwd_addr_o), .fwd_wdata_i(fwd_wdata_o), .rdata_o(fwd_rdata_i));

    // one bus access, held for exactly one taking edge
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        bus_req_i <= '{cs: 1'b1, rd: ~w, wr: w, addr: a, wdata: d};
        @(posedge core_clk_i);
        bus_req_i <= '0;
        #1;
    endtask : acc

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK("rdata_o", e, rdata_o)
    endtask : rd

    task automatic t_reset;
        `CHK("data_bits", 4'h5, fmt_o.data_bits)
        `CHK("stop_halves", 3'h2, fmt_o.stop_halves)
        `CHK("serial_tx_line_o", 1'b1, serial_tx_line_o)
        rd(3'h3, 8'h00);
    endtask : t_reset

    task automatic t_format;
        logic [7:0] v;
        logic [2:0] sh;
        for (int i = 0; i < 8; i++) begin
            v = 8'(i);
            sh = !v[2] ? 3'h2 : (v[1:0] == 2'h0 ? 3'h3 : 3'h4);
            acc(1'b1, 3'h3, v);
            `CHK("data_bits", 4'h5 + v[1:0], fmt_o.data_bits)
            `CHK("stop_halves", sh, fmt_o.stop_halves)
            `CHK("frame_ticks", 8'(16 * (6 + v[1:0]) + 8 * sh), fmt_o.frame_ticks)
            rd(3'h3, v);
        end
    endtask : t_format

    // every parity mode at five and eight bits; upper data bits must be masked
    task automatic t_parity;
        logic [2:0] md [5] = '{3'b110, 3'b001, 3'b011, 3'b101, 3'b111};
        logic [7:0] d [3] = '{8'h00, 8'hb5, 8'h9e};
        logic       p;
        for (int m = 0; m < 5; m++) begin
            for (int l = 0; l < 4; l += 3) begin
                acc(1'b1, 3'h3, {2'b00, md[m], 1'b0, 2'(l)});
                `CHK("frame_ticks", 8'(16 * (7 + l + md[m][0])), fmt_o.frame_ticks)
                for (int k = 0; k < 6; k++) begin
                    @(posedge core_clk_i);
                    tx_data_i <= d[k/2];
                    rx_data_i <= d[k/2];
                    rx_parity_i <= k[0];
                    p = md[m][2] ? ~md[m][1] : ^(d[k/2] & (8'hff >> (3 - l))) ^ ~md[m][1];
                    @(posedge core_clk_i);
                    #1;
                    `CHK("tx_parity_o", md[m][0] & p, tx_parity_o)
                    `CHK("rx_parity_err_o", md[m][0] & (k[0] ^ p), rx_parity_err_o)
                end
            end
        end
    endtask : t_parity

    // transmitter level toggles; break must mask it until cleared
    task automatic t_line(input logic brk);
        acc(1'b1, 3'h3, {1'b0, brk, 6'h03});
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk_i);
            tx_line_i <= i[0];
            #1;
            if (i > 0) `CHK("serial_tx_line_o", ~brk & ~i[0], serial_tx_line_o)
        end
    endtask : t_line

    task automatic t_bank;
        acc(1'b1, 3'h0, 8'h5a);
        `CHK("fwd_wr_o", 1'b1, fwd_wr_o)
        `CHK("fwd_wdata_o", 8'h5a, fwd_wdata_o)
        rd(3'h0, 8'h5a);
        `CHK("fwd_rd_o", 1'b1, fwd_rd_o)
        acc(1'b1, 3'h3, 8'h80);
        acc(1'b1, 3'h0, 8'h34);
        `CHK("fwd_wr_o", 1'b0, fwd_wr_o)
        acc(1'b1, 3'h1, 8'h12);
        rd(3'h0, 8'h34);
        rd(3'h1, 8'h12);
        rd(3'h3, 8'h80);
        acc(1'b1, 3'h3, 8'h00);
        rd(3'h0, 8'h5a);
        acc(1'b1, 3'h1, 8'hc3);
        `CHK("fwd_addr_o", 3'h1, fwd_addr_o)
        rd(3'h1, 8'hc3);
    endtask : t_bank

    // first tick n+1 edges after the divisor write, then every n
    task automatic tick_run(input int n);
        for (int i = 1; i <= 2 * n + 1; i++) begin
            @(posedge core_clk_i);
            #1;
            `CHK("tick16_o", i > n && (i - n - 1) % n == 0, tick16_o)
        end
    endtask : tick_run

    task automatic t_baud;
        acc(1'b1, 3'h3, 8'h80);
        acc(1'b1, 3'h1, 8'h00);
        acc(1'b1, 3'h0, 8'h03);
        tick_run(3);
        acc(1'b1, 3'h0, 8'h01);
        tick_run(1);
        // a line-rate divisor: near 15.6K baud from the core clock reference
        acc(1'b1, 3'h0, 8'hc8);
        repeat (50) @(posedge core_clk_i);
        acc(1'b1, 3'h0, 8'h04);
        tick_run(4);
        acc(1'b1, 3'h1, 8'h01);
        tick_run(260);
        acc(1'b1, 3'h3, 8'h00);
    endtask : t_baud

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_format();
        t_parity();
        t_line(1'b1);
        t_line(1'b1);
        t_line(1'b0);
        t_bank();
        t_baud();
        final_report();
    end

    // the whole run needs under a thousand cycles; this is far beyond that
    initial begin
        #1000000;
        n_fail++;
        final_report();
    end
endmodule : ufb_format_baud_tb
